// *** core/bdm_regfile.sv ***
// Banked data memory: address decode, pointers, bank select, indirect access.
// Assumes a core on mclk issuing one access per cycle; peripheral registers
// sit outside behind the per-cycle special-register port.
//
// Operation
// - Memory is byte wide; special and general areas are contiguous from zero.
// - Special registers decode the same whatever bank is selected.
// - Single-bit set and clear work on every location except protected bits.
// - Unused special locations read back as zero.
// - Protected registers or bits are read-only; writes leave them unchanged.
// - Accesses to an indirect window act on the address in its pointer.
// - First pointer reaches bank zero only; second pointer reaches all banks.
// - Pointer aimed at an indirect window reads zero and ignores writes.
// - Two real 8-bit pointers behave like ordinary registers.
// - Bank select bits 0 and 1 choose the data memory bank.
// - Reset returns bank to zero, except watchdog time-out in power down.
`include "bdm_map.svh"

module bdm_regfile #(
    parameter int banks = 4,
    parameter int bank_depth = 192,
    parameter int sfr_top = 64
) (
    input wire logic mclk,
    input wire logic rst,
    input wire bdm_pkg::bdm_byte_t addr,
    input wire logic rd_en,
    input wire bdm_pkg::bdm_op_e op,
    input wire logic [2:0] bit_idx,
    input wire bdm_pkg::bdm_byte_t wdata,
    input wire logic sys_reset_req,
    input wire logic wdt_pd_reset,
    input wire bdm_pkg::bdm_byte_t sfr_rdata,
    input wire logic sfr_present,
    input wire bdm_pkg::bdm_byte_t sfr_ro_mask,
    output bdm_pkg::bdm_byte_t rdata,
    output logic rvalid,
    output bdm_pkg::bdm_byte_t sfr_addr_q,
    output logic sfr_wr_q,
    output bdm_pkg::bdm_byte_t sfr_wdata_q,
    output bdm_pkg::bdm_byte_t pointer_zero,
    output bdm_pkg::bdm_byte_t pointer_one,
    output bdm_pkg::bdm_byte_t bank_select
);
    import bdm_pkg::*;

    localparam int mem_words = banks * bank_depth;
    localparam int idx_w = $clog2(mem_words);

    bdm_byte_t ram [mem_words];
    bdm_byte_t eff_addr;
    bdm_bank_t eff_bank;
    logic eff_null;
    logic is_gp;
    logic gp_ok;
    logic [idx_w-1:0] gp_idx;
    bdm_byte_t cur_data;
    bdm_byte_t next_data;
    bdm_byte_t wr_mask;
    logic do_wr;
    logic wr_ptr0;
    logic wr_ptr1;
    logic wr_bank;
    logic wr_sfr;

    // Flat index of a general purpose byte in the given bank
    function automatic logic [idx_w-1:0] gp_index(input bdm_bank_t b, input bdm_byte_t a);
        logic [31:0] full;
        full = 32'(b) * 32'(bank_depth) + 32'(a) - 32'(`BDM_GP_BASE);
        return full[idx_w-1:0];
    endfunction

    // Indirect window test applied to the redirected address of either pointer
    function automatic logic is_window(input bdm_byte_t a);
        return (a == `BDM_OFS_INDIRECT_WINDOW_ZERO) || (a == `BDM_OFS_INDIRECT_WINDOW_ONE);
    endfunction

    // External special registers sit above the local ones and below the general area
    function automatic logic in_sfr_area(input bdm_byte_t a);
        return (32'(a) < 32'(sfr_top)) && (a > `BDM_OFS_BANK_SELECT);
    endfunction

    // Write strobe for one register kept in this block
    function automatic logic local_wr(input logic wr, input logic gp, input bdm_byte_t a,
                                      input bdm_byte_t target);
        return wr && !gp && (a == target);
    endfunction

    // Address redirection
    always_comb begin
        eff_addr = addr;
        eff_bank = bank_select[`BDM_BANK_MSB:`BDM_BANK_LSB];
        eff_null = 1'b0;
        if (addr == `BDM_OFS_INDIRECT_WINDOW_ZERO) begin
            eff_addr = pointer_zero;
            eff_bank = 2'h0;
            eff_null = is_window(pointer_zero);
        end else if (addr == `BDM_OFS_INDIRECT_WINDOW_ONE) begin
            eff_addr = pointer_one;
            eff_null = is_window(pointer_one);
        end
    end

    // Special area ignores the bank entirely
    always_comb begin
        is_gp = (eff_addr >= `BDM_GP_BASE);
        gp_ok = is_gp && (32'(eff_addr) - 32'(`BDM_GP_BASE) < 32'(bank_depth));
        gp_idx = gp_index(eff_bank, eff_addr);
    end

    // Current contents of the target, zero where nothing lives
    always_comb begin
        cur_data = 8'h00;
        wr_mask = 8'h00;
        if (eff_null) begin
            cur_data = 8'h00;
            wr_mask = 8'h00;
        end else if (is_gp) begin
            if (gp_ok) begin
                cur_data = ram[gp_idx];
                wr_mask = 8'hff;
            end
        end else if (eff_addr == `BDM_OFS_POINTER_ZERO) begin
            cur_data = pointer_zero;
            wr_mask = 8'hff;
        end else if (eff_addr == `BDM_OFS_POINTER_ONE) begin
            cur_data = pointer_one;
            wr_mask = 8'hff;
        end else if (eff_addr == `BDM_OFS_BANK_SELECT) begin
            cur_data = bank_select;
            wr_mask = `BDM_BANK_SELECT_WMASK;
        end else if (in_sfr_area(eff_addr) && sfr_present) begin
            cur_data = sfr_rdata;
            wr_mask = ~sfr_ro_mask;
        end
    end

    // Whole-byte write or read-modify-write of one bit
    always_comb begin
        next_data = cur_data;
        case (op)
            bdm_op_write: next_data = wdata;
            bdm_op_set: next_data = cur_data | (8'h01 << bit_idx);
            bdm_op_clr: next_data = cur_data & ~(8'h01 << bit_idx);
            default: next_data = cur_data;
        endcase
        // Protected bits keep their old value, so bit ops skip them too
        next_data = (next_data & wr_mask) | (cur_data & ~wr_mask);
        do_wr = (op != bdm_op_none) && !eff_null;
    end

    // One strobe per target keeps the register processes short
    always_comb begin
        wr_ptr0 = local_wr(do_wr, is_gp, eff_addr, `BDM_OFS_POINTER_ZERO);
        wr_ptr1 = local_wr(do_wr, is_gp, eff_addr, `BDM_OFS_POINTER_ONE);
        wr_bank = local_wr(do_wr, is_gp, eff_addr, `BDM_OFS_BANK_SELECT);
        wr_sfr = do_wr && !is_gp && in_sfr_area(eff_addr) && sfr_present && (wr_mask != 8'h00);
    end

    // General purpose storage; no reset, contents are undefined at power-up
    always_ff @(posedge mclk) begin
        if (do_wr && gp_ok) begin
            ram[gp_idx] <= next_data;
        end
    end

    // Pointers reset to zero, so a stray indirect access hits a window and is dropped
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pointer_zero <= `BDM_RST_POINTER;
        end else if (wr_ptr0) begin
            pointer_zero <= next_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pointer_one <= `BDM_RST_POINTER;
        end else if (wr_ptr1) begin
            pointer_one <= next_data;
        end
    end

    // A reset request wins over a same-cycle write so the bank is never stale
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bank_select <= `BDM_RST_BANK_SELECT;
        end else if (sys_reset_req) begin
            if (!wdt_pd_reset) begin
                bank_select <= `BDM_RST_BANK_SELECT;
            end
        end else if (wr_bank) begin
            // Program bank bits live elsewhere; only the data bank bits are stored
            bank_select <= next_data;
        end
    end

    // Peripheral writes leave one cycle late, keeping every output on a flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sfr_wr_q <= 1'b0;
            sfr_addr_q <= 8'h00;
            sfr_wdata_q <= 8'h00;
        end else begin
            sfr_wr_q <= wr_sfr;
            sfr_addr_q <= eff_addr;
            sfr_wdata_q <= next_data;
        end
    end

    // Idle read data is forced to zero so a late sample never shows a stale byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd_en;
            rdata <= rd_en ? cur_data : 8'h00;
        end
    end
endmodule

// *** core/bdm_map.svh ***
// Address map, field positions and reset values of the banked data memory.
// Assumes 8-bit data addresses with the special area below the general area.
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH

`define BDM_OFS_INDIRECT_WINDOW_ZERO 8'h00
`define BDM_OFS_POINTER_ZERO         8'h01
`define BDM_OFS_INDIRECT_WINDOW_ONE  8'h02
`define BDM_OFS_POINTER_ONE          8'h03
`define BDM_OFS_BANK_SELECT          8'h04
`define BDM_GP_BASE                  8'h40
`define BDM_BANK_LSB                 0
`define BDM_BANK_MSB                 1
`define BDM_BANK_SELECT_WMASK        8'h03
`define BDM_RST_POINTER              8'h00
`define BDM_RST_BANK_SELECT          8'h00

`endif

// *** core/bdm_pkg.sv ***
// Types shared by the banked data memory and its bench.
// Assumes the map header is compiled alongside.
package bdm_pkg;
    typedef logic [7:0] bdm_byte_t;
    typedef logic [1:0] bdm_bank_t;
    typedef enum logic [1:0] {
        bdm_op_none = 2'b00,
        bdm_op_write = 2'b01,
        bdm_op_set = 2'b10,
        bdm_op_clr = 2'b11
    } bdm_op_e;
endpackage

// *** tb/bdm_regfile_asserts.sv ***
// Port checker for the banked data memory.
// Assumes it is bound into every instance of the block and sees its ports.
module bdm_regfile_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire bdm_pkg::bdm_byte_t addr,
    input wire logic rd_en,
    input wire bdm_pkg::bdm_op_e op,
    input wire bdm_pkg::bdm_byte_t wdata,
    input wire logic sys_reset_req,
    input wire logic wdt_pd_reset,
    input wire logic sfr_present,
    input wire bdm_pkg::bdm_byte_t rdata,
    input wire logic rvalid,
    input wire bdm_pkg::bdm_byte_t pointer_zero,
    input wire bdm_pkg::bdm_byte_t bank_select
);
    timeunit 1ns;
    timeprecision 1ps;
    import bdm_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (rd_en |=> rvalid) else $error("no rvalid");
    chk_idle_quiet:
        assert property (!rd_en |=> !rvalid && rdata == 8'h00) else $error("idle rdata");
    chk_bank_upper: assert property (bank_select[7:2] == 6'h00) else $error("bank bits");
    chk_bank_write:
        assert property (op == bdm_op_write && addr == 8'h04 && !sys_reset_req
            |=> bank_select[1:0] == $past(wdata[1:0])) else $error("bank write");
    chk_bank_reset:
        assert property (sys_reset_req && !wdt_pd_reset |=> bank_select == 8'h00)
            else $error("bank reset");
    chk_bank_hold:
        assert property (sys_reset_req && wdt_pd_reset && op == bdm_op_none
            |=> $stable(bank_select)) else $error("bank hold");
    chk_ptr_write:
        assert property (op == bdm_op_write && addr == 8'h01 |=> pointer_zero == $past(wdata))
            else $error("pointer write");
    chk_unused_zero:
        assert property (rd_en && addr inside {[8'h05:8'h3f]} && !sfr_present
            |=> rdata == 8'h00) else $error("unused read");
    chk_window_self:
        assert property (rd_en && addr == 8'h00 && pointer_zero inside {8'h00, 8'h02}
            |=> rdata == 8'h00) else $error("self window");
endmodule

bind bdm_regfile bdm_regfile_asserts u_chk (.*);

// *** tb/bdm_core_model.sv ***
// Core-side model: one data memory access per task call.
// Assumes rdata answers one cycle after the read edge.
module bdm_core_model (
    input wire logic mclk,
    output bdm_pkg::bdm_byte_t addr,
    output logic rd_en,
    output bdm_pkg::bdm_op_e op,
    output logic [2:0] bit_idx,
    output bdm_pkg::bdm_byte_t wdata,
    input wire bdm_pkg::bdm_byte_t rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import bdm_pkg::*;
    initial begin
        addr = 8'h00;
        rd_en = 1'b0;
        op = bdm_op_none;
        bit_idx = 3'h0;
        wdata = 8'h00;
    end
    // Caller loads bank select before general accesses
    task automatic acc(input bdm_op_e o, input bdm_byte_t a, input bdm_byte_t d,
                       input logic [2:0] i);
        @(posedge mclk);
        op <= o;
        addr <= a;
        wdata <= d;
        bit_idx <= i;
        @(posedge mclk);
        op <= bdm_op_none;
    endtask
    task automatic rd(input bdm_byte_t a, output bdm_byte_t q);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 q = rdata;
    endtask
endmodule

// *** tb/banked_data_memory_indirect_access_test.sv ***
// Self-checking bench for the banked data memory.
// Assumes one stand-in peripheral register, driven here, answers at 10h.
module banked_data_memory_indirect_access_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bdm_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sys_reset_req = 1'b0;
    logic wdt_pd_reset = 1'b0;
    logic sfr_present = 1'b0;
    logic sfr_wr_q;
    bdm_byte_t sfr_rdata = 8'h00, sfr_ro_mask = 8'h00, sfr_addr_q, sfr_wdata_q;
    logic rd_en;
    logic [2:0] bit_idx;
    bdm_op_e op;
    bdm_byte_t addr, wdata, rdata, pointer_zero, pointer_one, bank_select, q;
    int err_count = 0;
    int checks = 0;
    always #2 mclk = ~mclk;
    bdm_core_model u_core (.mclk(mclk), .addr(addr), .rd_en(rd_en), .op(op),
        .bit_idx(bit_idx), .wdata(wdata), .rdata(rdata));
    bdm_regfile u_dut (.mclk(mclk), .rst(rst), .addr(addr), .rd_en(rd_en), .op(op),
        .bit_idx(bit_idx), .wdata(wdata), .sys_reset_req(sys_reset_req),
        .wdt_pd_reset(wdt_pd_reset), .sfr_rdata(sfr_rdata), .sfr_present(sfr_present),
        .sfr_ro_mask(sfr_ro_mask), .rdata(rdata), .rvalid(), .sfr_addr_q(sfr_addr_q),
        .sfr_wr_q(sfr_wr_q), .sfr_wdata_q(sfr_wdata_q), .pointer_zero(pointer_zero),
        .pointer_one(pointer_one),
        .bank_select(bank_select));
    task automatic chk(input string n, input bdm_byte_t e, input bdm_byte_t g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input bdm_byte_t a, input bdm_byte_t d);
        u_core.acc(bdm_op_write, a, d, 3'h0);
    endtask
    task automatic rchk(input string n, input bdm_byte_t a, input bdm_byte_t e);
        u_core.rd(a, q);
        chk(n, e, q);
    endtask
    task automatic pulse(input logic w);
        @(posedge mclk);
        sys_reset_req <= 1'b1;
        wdt_pd_reset <= w;
        @(posedge mclk);
        sys_reset_req <= 1'b0;
    endtask
    task automatic stop_test();
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk("pointer_one", 8'h00, pointer_one);
        rchk("bank_select", 8'h04, 8'h00);
        wr(8'h40, 8'ha5);
        wr(8'h04, 8'hfd);
        rchk("bank_select", 8'h04, 8'h01);
        wr(8'h40, 8'h3c);
        rchk("bank1 40h", 8'h40, 8'h3c);
        wr(8'h01, 8'h40);
        rchk("pointer_zero", 8'h01, 8'h40);
        rchk("window zero", 8'h00, 8'ha5);
        wr(8'h03, 8'h40);
        rchk("window one", 8'h02, 8'h3c);
        wr(8'h02, 8'h77);
        rchk("bank1 40h", 8'h40, 8'h77);
        u_core.acc(bdm_op_set, 8'h00, 8'h00, 3'h6);
        u_core.acc(bdm_op_clr, 8'h00, 8'h00, 3'h0);
        rchk("bit ops", 8'h00, 8'he4);
        u_core.acc(bdm_op_set, 8'h04, 8'h00, 3'h5);
        rchk("bank bit5", 8'h04, 8'h01);
        rchk("unused", 8'h2c, 8'h00);
        wr(8'h01, 8'h02);
        wr(8'h00, 8'h55);
        rchk("self window", 8'h00, 8'h00);
        rchk("bank1 40h", 8'h40, 8'h77);
        wr(8'h04, 8'h03);
        pulse(1'b1);
        rchk("bank kept", 8'h04, 8'h03);
        pulse(1'b0);
        rchk("bank cleared", 8'h04, 8'h00);
        rchk("pointer kept", 8'h01, 8'h02);
        rchk("bank0 40h", 8'h40, 8'he4);
        wr(8'h04, 8'h02);
        @(posedge mclk);
        sfr_present <= 1'b1;
        sfr_rdata <= 8'h5a;
        sfr_ro_mask <= 8'hf0;
        wr(8'h10, 8'h33);
        #1 chk("sfr wdata", 8'h53, sfr_wdata_q);
        chk("sfr addr", 8'h10, sfr_addr_q);
        chk("sfr strobe", 8'h01, {7'h00, sfr_wr_q});
        u_core.acc(bdm_op_set, 8'h10, 8'h00, 3'h7);
        #1 chk("sfr bit7", 8'h5a, sfr_wdata_q);
        rchk("sfr read", 8'h10, 8'h5a);
        @(posedge mclk);
        sfr_present <= 1'b0;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk("bank after rst", 8'h04, 8'h00);
        rchk("pointer after rst", 8'h01, 8'h00);
        rchk("ram after rst", 8'h40, 8'he4);
        stop_test();
    end
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule
